// ---- logic/srcr_defines.vh ----
`ifndef SRCR_DEFINES_VH
`define SRCR_DEFINES_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define SRCR_ADDR_W 8
`define SRCR_OFS_TICK_COUNT 8'h00
`define SRCR_OFS_SUMMARY 8'h01
`define SRCR_OFS_SUPPLY 8'h02

// ----------------------------------------------------------------
// summary register bit positions
// ----------------------------------------------------------------
`define SRCR_SUM_DSP 7
`define SRCR_SUM_LINK 5
`define SRCR_SUM_MEMTEMP 4
`define SRCR_SUM_SUPPLY 3
`define SRCR_SUM_TEST 2
`define SRCR_SUM_RESET 1
`define SRCR_SUM_INIT 0
`define SRCR_SUM_RSVD 6

// ----------------------------------------------------------------
// supply fault register bit positions
// ----------------------------------------------------------------
`define SRCR_SUP_UV 7
`define SRCR_SUP_AREG 3
`define SRCR_SUP_DREG 2
`define SRCR_SUP_MREG 1
`define SRCR_SUP_CONT 0
`define SRCR_SUP_NUM 5
`define SRCR_MON_UV 4
`define SRCR_MON_AREG 3
`define SRCR_MON_DREG 2
`define SRCR_MON_MREG 1
`define SRCR_MON_CONT 0

// ----------------------------------------------------------------
// widths and reset values
// ----------------------------------------------------------------
`define SRCR_DATA_W 8
`define SRCR_PRESC_W 10
`define SRCR_COUNT_RST 8'h00
`define SRCR_PRESC_RST 10'h000
`define SRCR_BYTE_ZERO 8'h00
`define SRCR_TIMER_W 24

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SRCR_PRESC_DIV 1000
`define SRCR_PRESC_LAST 10'h3e7
`define SRCR_CLK_PERIOD_NS 8
`define SRCR_RECOVERY_NS 100000
`define SRCR_DATA_VALID_NS 1000000

`endif

// ---- logic/srcr_sync.v ----
`timescale 1ns/1ps

// ----------------------------------------------------------------
// two-stage synchroniser for asynchronous monitor levels
// ----------------------------------------------------------------
module srcr_sync #(
  parameter WIDTH = 1
) (
  // clock, reset, enable
  input wire clk,
  input wire rst_n,
  input wire ce,
  // levels
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] stage1_r;

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      stage1_r <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end
    else if (ce)
    begin
      stage1_r <= async_in;
      sync_out <= stage1_r;
    end
  end

endmodule

// ---- logic/srcr_regs.v ----
// Contract
// RULE_01: read-only 8-bit free-running wrapping counter
// RULE_02: prescaler divides oscillator by 1000
// RULE_03: prescaler, counter zero at reset; advance together
// RULE_04: status registers read-only over either interface
// RULE_05: summary bit 7 ORs processor faults
// RULE_06: summary bit 5 equals output mismatch flag
// RULE_07: summary bit 4 ORs five memory/temp flags
// RULE_08: summary bit 3 ORs five supply flags
// RULE_09: summary bit 2 shows test mode
// RULE_10: summary bit 1 set by reset, cleared by read
// RULE_11: summary bit 0 clears when data valid
// RULE_12: supply bit 7 flags undervoltage
// RULE_13: supply bit 3 flags analog regulator fault
// RULE_14: supply bit 2 flags digital regulator fault
// RULE_15: supply bit 1 flags memory regulator fault
// RULE_16: supply bit 0 flags continuity break
// RULE_17: shared recovery timer; clearing follows disable setting
// RULE_18: host ignores supply flags during reset
`timescale 1ns/1ps
`include "srcr_defines.vh"

module srcr_regs #(
  parameter RECOVERY_CYC = (`SRCR_RECOVERY_NS + `SRCR_CLK_PERIOD_NS - 1) / `SRCR_CLK_PERIOD_NS,
  parameter DATA_VALID_CYC = (`SRCR_DATA_VALID_NS + `SRCR_CLK_PERIOD_NS - 1) / `SRCR_CLK_PERIOD_NS
) (
  // clock, reset, enable
  input wire clk,
  input wire rst_n,
  input wire ce,
  // register read port from the serial front end
  input wire rd_en,
  input wire [`SRCR_ADDR_W-1:0] rd_addr,
  output reg [`SRCR_DATA_W-1:0] rd_data_r,
  output reg rd_valid_r,
  // status field transmitted by the front end
  input wire status_tx_clr,
  // signal processor flags
  input wire selftest_incomplete,
  input wire common_mode_fault,
  input wire selftest_fault,
  // link and memory/temperature flags
  input wire link_error_summary,
  input wire factory_mem_fault,
  input wire user_mem_fault,
  input wire user_reg_check_fault,
  input wire user_mem_write_active,
  input wire temperature_fault,
  // mode and control
  input wire test_mode_active,
  input wire supply_report_disable,
  // analog monitors, asynchronous
  input wire supply_undervoltage,
  input wire analog_regulator_fault,
  input wire digital_regulator_fault,
  input wire memory_regulator_fault,
  input wire continuity_fault,
  // state views
  output reg [`SRCR_DATA_W-1:0] tick_count_r,
  output reg init_in_progress_r
);

  // ----------------------------------------------------------------
  // constants
  // ----------------------------------------------------------------
  localparam [`SRCR_PRESC_W-1:0] PRESC_LAST = `SRCR_PRESC_LAST;
  localparam [`SRCR_TIMER_W-1:0] RECOVERY_LOAD = RECOVERY_CYC[`SRCR_TIMER_W-1:0];
  localparam [`SRCR_TIMER_W-1:0] DATA_VALID_LOAD = DATA_VALID_CYC[`SRCR_TIMER_W-1:0];
  localparam [`SRCR_TIMER_W-1:0] TIMER_ZERO = {`SRCR_TIMER_W{1'b0}};
  localparam [`SRCR_TIMER_W-1:0] TIMER_ONE = {{(`SRCR_TIMER_W-1){1'b0}}, 1'b1};

  // ----------------------------------------------------------------
  // monitor synchronisation
  // ----------------------------------------------------------------
  wire [`SRCR_SUP_NUM-1:0] mon_async;
  wire [`SRCR_SUP_NUM-1:0] mon_sync;

  assign mon_async[`SRCR_MON_UV] = supply_undervoltage;
  assign mon_async[`SRCR_MON_AREG] = analog_regulator_fault;
  assign mon_async[`SRCR_MON_DREG] = digital_regulator_fault;
  assign mon_async[`SRCR_MON_MREG] = memory_regulator_fault;
  assign mon_async[`SRCR_MON_CONT] = continuity_fault;

  srcr_sync #(
    .WIDTH(`SRCR_SUP_NUM)
  ) u_mon_sync (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .async_in(mon_async),
    .sync_out(mon_sync)
  );

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg [`SRCR_PRESC_W-1:0] presc_r;
  reg [`SRCR_PRESC_W-1:0] presc_nxt;
  reg [`SRCR_DATA_W-1:0] tick_count_nxt;
  reg reset_occurred_r;
  reg reset_occurred_nxt;
  reg init_in_progress_nxt;
  reg [`SRCR_TIMER_W-1:0] init_timer_r;
  reg [`SRCR_TIMER_W-1:0] init_timer_nxt;
  reg [`SRCR_DATA_W-1:0] supply_r;
  reg [`SRCR_DATA_W-1:0] supply_nxt;
  reg [`SRCR_TIMER_W-1:0] rcv_timer_r;
  reg [`SRCR_TIMER_W-1:0] rcv_timer_nxt;
  reg [`SRCR_DATA_W-1:0] rd_data_nxt;
  reg [`SRCR_DATA_W-1:0] sup_set;
  reg rd_sel_count;
  reg rd_sel_summary;
  reg rd_sel_supply;

  wire rd_summary;
  wire rd_supply;
  wire presc_wrap;
  wire sup_fault_now;
  wire rcv_expired;
  wire sup_clear;
  wire [`SRCR_DATA_W-1:0] summary;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  always @*
  begin
    rd_sel_count = 1'b0;
    rd_sel_summary = 1'b0;
    rd_sel_supply = 1'b0;
    if (rd_addr == `SRCR_OFS_TICK_COUNT)
    begin
      rd_sel_count = 1'b1;
    end
    else if (rd_addr == `SRCR_OFS_SUMMARY)
    begin
      rd_sel_summary = 1'b1;
    end
    else if (rd_addr == `SRCR_OFS_SUPPLY)
    begin
      rd_sel_supply = 1'b1;
    end
  end

  assign rd_summary = rd_en && rd_sel_summary;
  assign rd_supply = rd_en && rd_sel_supply;

  // ----------------------------------------------------------------
  // prescaler and rolling counter
  // ----------------------------------------------------------------
  assign presc_wrap = (presc_r == PRESC_LAST); // RULE_02

  always @*
  begin
    presc_nxt = presc_r + 1'b1; // RULE_02
    tick_count_nxt = tick_count_r;
    if (presc_wrap)
    begin
      presc_nxt = `SRCR_PRESC_RST;
      tick_count_nxt = tick_count_r + 1'b1; // RULE_01 RULE_03
    end
  end

  // ----------------------------------------------------------------
  // supply faults with shared recovery timer
  // ----------------------------------------------------------------
  always @*
  begin
    sup_set = `SRCR_BYTE_ZERO;
    sup_set[`SRCR_SUP_UV] = mon_sync[`SRCR_MON_UV]; // RULE_12
    sup_set[`SRCR_SUP_AREG] = mon_sync[`SRCR_MON_AREG]; // RULE_13
    sup_set[`SRCR_SUP_DREG] = mon_sync[`SRCR_MON_DREG]; // RULE_14
    sup_set[`SRCR_SUP_MREG] = mon_sync[`SRCR_MON_MREG]; // RULE_15
    sup_set[`SRCR_SUP_CONT] = mon_sync[`SRCR_MON_CONT]; // RULE_16
  end

  assign sup_fault_now = |mon_sync;
  assign rcv_expired = (rcv_timer_r == TIMER_ZERO) && !sup_fault_now;
  // disabled: auto clear on expiry; enabled: held until read after expiry
  assign sup_clear = rcv_expired && (supply_report_disable || rd_supply); // RULE_17

  always @*
  begin
    rcv_timer_nxt = rcv_timer_r;
    if (sup_fault_now)
    begin
      rcv_timer_nxt = RECOVERY_LOAD; // RULE_17
    end
    else if (rcv_timer_r != TIMER_ZERO)
    begin
      rcv_timer_nxt = rcv_timer_r - TIMER_ONE;
    end
    supply_nxt = supply_r;
    if (sup_clear)
    begin
      supply_nxt = `SRCR_BYTE_ZERO; // RULE_17
    end
    // a new fault wins over the clear
    supply_nxt = supply_nxt | sup_set; // RULE_17
  end

  // ----------------------------------------------------------------
  // reset indication
  // ----------------------------------------------------------------
  always @*
  begin
    reset_occurred_nxt = reset_occurred_r;
    if (rd_summary || status_tx_clr)
    begin
      reset_occurred_nxt = 1'b0; // RULE_10
    end
  end

  // ----------------------------------------------------------------
  // initialisation delay
  // ----------------------------------------------------------------
  always @*
  begin
    init_timer_nxt = init_timer_r;
    init_in_progress_nxt = init_in_progress_r;
    if (init_timer_r != TIMER_ZERO)
    begin
      init_timer_nxt = init_timer_r - TIMER_ONE;
    end
    else
    begin
      init_in_progress_nxt = 1'b0; // RULE_11
    end
  end

  // ----------------------------------------------------------------
  // summary assembly
  // ----------------------------------------------------------------
  assign summary[`SRCR_SUM_DSP] = selftest_incomplete | common_mode_fault |
                                  selftest_fault; // RULE_05
  assign summary[`SRCR_SUM_RSVD] = 1'b0;
  assign summary[`SRCR_SUM_LINK] = link_error_summary; // RULE_06
  assign summary[`SRCR_SUM_MEMTEMP] = factory_mem_fault | user_mem_fault |
                                      user_reg_check_fault | user_mem_write_active |
                                      temperature_fault; // RULE_07
  assign summary[`SRCR_SUM_SUPPLY] = supply_r[`SRCR_SUP_UV] | supply_r[`SRCR_SUP_AREG] |
                                     supply_r[`SRCR_SUP_DREG] | supply_r[`SRCR_SUP_MREG] |
                                     supply_r[`SRCR_SUP_CONT]; // RULE_08
  assign summary[`SRCR_SUM_TEST] = test_mode_active; // RULE_09
  assign summary[`SRCR_SUM_RESET] = reset_occurred_r; // RULE_10
  assign summary[`SRCR_SUM_INIT] = init_in_progress_r; // RULE_11

  // ----------------------------------------------------------------
  // read mux, read-only: no write path exists
  // ----------------------------------------------------------------
  always @*
  begin
    rd_data_nxt = rd_data_r;
    if (rd_en)
    begin
      if (rd_sel_count)
      begin
        rd_data_nxt = tick_count_r; // RULE_01 RULE_04
      end
      else if (rd_sel_summary)
      begin
        rd_data_nxt = summary; // RULE_04
      end
      else if (rd_sel_supply)
      begin
        rd_data_nxt = supply_r; // RULE_04
      end
      else
      begin
        rd_data_nxt = `SRCR_BYTE_ZERO;
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      presc_r <= `SRCR_PRESC_RST; // RULE_03
      tick_count_r <= `SRCR_COUNT_RST; // RULE_03
      reset_occurred_r <= 1'b1; // RULE_10
      init_in_progress_r <= 1'b1; // RULE_11
      init_timer_r <= DATA_VALID_LOAD;
      supply_r <= `SRCR_BYTE_ZERO;
      rcv_timer_r <= TIMER_ZERO;
      rd_data_r <= `SRCR_BYTE_ZERO;
      rd_valid_r <= 1'b0;
    end
    else if (ce)
    begin
      presc_r <= presc_nxt;
      tick_count_r <= tick_count_nxt;
      reset_occurred_r <= reset_occurred_nxt;
      init_in_progress_r <= init_in_progress_nxt;
      init_timer_r <= init_timer_nxt;
      supply_r <= supply_nxt;
      rcv_timer_r <= rcv_timer_nxt;
      rd_data_r <= rd_data_nxt;
      rd_valid_r <= rd_en;
    end
  end

endmodule

// ---- tb/srcr_monitor.sv ----
`timescale 1ns/1ps

// ----
// register bank checker
// ----
module srcr_monitor (
  input logic clk,
  input logic rst_n,
  input logic ce,
  input logic rd_en,
  input logic [7:0] rd_addr,
  input logic [7:0] rd_data_r,
  input logic rd_valid_r,
  input logic [7:0] tick_count_r,
  input logic init_in_progress_r
);
  logic [9:0] pm_r;
  logic seen_r;
  wire tk = rd_en && ce;
  wire sum_rd = tk && rd_addr == 8'h01;
  // prescaler mirror and summary-read history
  always_ff @(posedge clk)
  begin
    pm_r <= !rst_n ? 10'h000 : !ce ? pm_r : pm_r == 10'h3e7 ? 10'h000 : pm_r + 10'h001;
    seen_r <= rst_n && (seen_r || sum_rd);
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  rd_answer_a:
    assert property (tk |=> rd_valid_r) else $error("read not answered");
  rd_pulse_a:
    assert property (ce && !rd_en |=> !rd_valid_r) else $error("valid without read");
  unmapped_zero_a:
    assert property (tk && rd_addr > 8'h02 |=> rd_data_r == 8'h00) else $error("unmapped data");
  count_read_a:
    assert property (tk && rd_addr == 8'h00 |=> rd_data_r == $past(tick_count_r))
      else $error("count read");
  tick_step_a:
    assert property (ce && pm_r == 10'h3e7 |=> tick_count_r == $past(tick_count_r) + 8'h01)
      else $error("count step");
  tick_hold_a:
    assert property (!(ce && pm_r == 10'h3e7) |=> $stable(tick_count_r)) else $error("count moved");
  reset_view_a:
    assert property ($rose(rst_n) |-> tick_count_r == 8'h00 && init_in_progress_r)
      else $error("reset state");
  init_stays_a:
    assert property (!init_in_progress_r |=> !init_in_progress_r) else $error("init rose");
  reset_bit_clr_a:
    assert property (sum_rd && seen_r |=> !rd_data_r[1]) else $error("reset bit kept");
  supply_rsvd_a:
    assert property (tk && rd_addr == 8'h02 |=> rd_data_r[6:4] == 3'h0) else $error("rsvd set");
  cover property (sum_rd && seen_r);
  cover property (ce && pm_r == 10'h3e7);
  cover property ($fell(init_in_progress_r));
endmodule

bind srcr_regs srcr_monitor i_mon (.clk(clk), .rst_n(rst_n), .ce(ce), .rd_en(rd_en),
  .rd_addr(rd_addr), .rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r),
  .tick_count_r(tick_count_r), .init_in_progress_r(init_in_progress_r));

// ---- tb/srcr_host.sv ----
`timescale 1ns/1ps

// ----
// host on the register read port
// ----
module srcr_host (
  input logic clk,
  input logic rst_n,
  input logic [7:0] rd_data_r,
  input logic rd_valid_r,
  output logic rd_en,
  output logic [7:0] rd_addr
);
  initial
  begin
    rd_en = 1'b0;
    rd_addr = 8'h00;
  end
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic ok;
    ok = 1'b0;
    @(posedge clk);
    rd_en <= 1'b1;
    rd_addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    rd_addr <= ~a;
    for (int n = 0; n < 4 && !ok; n++)
    begin
      @(posedge clk);
      ok = rd_valid_r === 1'b1;
    end
    // supply flags read during reset are discarded
    d = !ok ? 8'hxx : (a == 8'h02 && !rst_n) ? 8'h00 : rd_data_r;
  endtask
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps

module tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic status_tx_clr = 1'b0;
  logic supply_report_disable = 1'b1;
  logic [9:0] fl = 10'h000;
  logic [4:0] sm = 5'h00;
  logic rd_en;
  logic [7:0] rd_addr;
  logic [7:0] rd_data_r;
  logic rd_valid_r;
  logic [7:0] d;
  int miscompares = 0;
  int samples_checked = 0;
  int cyc = 0;
  always #4 clk = ~clk;
  srcr_regs #(.RECOVERY_CYC(4), .DATA_VALID_CYC(10)) i_dut (
    .clk(clk), .rst_n(rst_n), .ce(ce), .rd_en(rd_en), .rd_addr(rd_addr),
    .rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r), .status_tx_clr(status_tx_clr),
    .selftest_incomplete(fl[0]), .common_mode_fault(fl[1]), .selftest_fault(fl[2]),
    .link_error_summary(fl[3]), .factory_mem_fault(fl[4]), .user_mem_fault(fl[5]),
    .user_reg_check_fault(fl[6]), .user_mem_write_active(fl[7]), .temperature_fault(fl[8]),
    .test_mode_active(fl[9]), .supply_report_disable(supply_report_disable),
    .supply_undervoltage(sm[4]), .analog_regulator_fault(sm[3]),
    .digital_regulator_fault(sm[2]), .memory_regulator_fault(sm[1]),
    .continuity_fault(sm[0]), .tick_count_r(), .init_in_progress_r());
  srcr_host i_host (.clk(clk), .rst_n(rst_n), .rd_data_r(rd_data_r),
    .rd_valid_r(rd_valid_r), .rd_en(rd_en), .rd_addr(rd_addr));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    i_host.rd(a, d);
    chk(d, exp);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic rst;
    @(posedge clk);
    rst_n <= 1'b0;
    wt(4);
    rst_n <= 1'b1;
  endtask
  task automatic print_verdict;
    $display("checked=%0d mismatches=%0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      miscompares++;
      print_verdict();
    end
  end
  initial
  begin
    rst();
    rc(8'h01, 8'h03);
    rc(8'h01, 8'h01);
    rc(8'h05, 8'h00);
    wt(8);
    rc(8'h01, 8'h00);
    rst();
    status_tx_clr <= 1'b1;
    @(posedge clk);
    status_tx_clr <= 1'b0;
    wt(12);
    rc(8'h01, 8'h00);
    for (int i = 0; i < 10; i++)
    begin
      fl <= 10'h001 << i;
      rc(8'h01, i < 3 ? 8'h80 : i == 3 ? 8'h20 : i < 9 ? 8'h10 : 8'h04);
    end
    fl <= 10'h000;
    for (int i = 0; i < 5; i++)
    begin
      sm <= 5'h01 << i;
      wt(5);
      rc(8'h02, {sm[4], 3'h0, sm[3:0]});
      rc(8'h01, 8'h08);
      sm <= 5'h00;
      wt(16);
      rc(8'h02, 8'h00);
    end
    supply_report_disable <= 1'b0;
    sm <= 5'h10;
    wt(5);
    sm <= 5'h00;
    wt(16);
    rc(8'h02, 8'h80);
    rc(8'h02, 8'h00);
    supply_report_disable <= 1'b1;
    rst();
    wt(1200);
    rc(8'h00, 8'h01);
    ce <= 1'b0;
    wt(600);
    ce <= 1'b1;
    wt(1300);
    rc(8'h00, 8'h02);
    print_verdict();
  end
endmodule
